/* design/bpm_cfg.svh */
// Register offsets, field positions and reset values of the supply monitor.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// Overview of operation
// [RULE1] Active detection without interrupt option makes a brownout reset the processor.
// [RULE2] Interrupt-select and brownout interrupt enable route brownout to an interrupt; the code also requires the global interrupt enable.
// [RULE3] Unprogrammed fuse enable disables detection regardless of mode and off bit.
// [RULE4] Power-mode field equal to binary 11 disables brownout detection.
// [RULE5] Detect-off bit set disables detection; it resets to zero.
// [RULE6] Brownout condition follows the comparator while detection is enabled.
// [RULE7] Enabled detection sets the brownout flag whether reset or interrupt follows.
// [RULE8] Brownout flag stays set until software writes zero to it.
// [RULE9] Software ignores the brownout flag while the fuse enable is unprogrammed.
// [RULE10] Power-on with fuse enable programmed sets brownout flag with power-on flag.
// [RULE11] Power-on detector sets the power-on flag on initial power-up.
// [RULE12] Power-on flag stays set until software writes zero to it.
// [RULE13] Interrupt mode delivers only with both enables; otherwise only the flag; the code still raises irq when irq mask bit 0 is set.
// [RULE14] Brownout interrupt wakes power-down only when enabled with global enable.
// [RULE15] Reset mode holds processor reset while the brownout condition persists.
`ifndef BPM_CFG_SVH
`define BPM_CFG_SVH
// Offsets are five bits wide so that the mask register at 0x10 decodes
`define BPM_ADR_POWER_CONTROL 5'h00
`define BPM_ADR_IRQ_ENABLE0   5'h04
`define BPM_ADR_RESET_SOURCE  5'h08
`define BPM_ADR_IRQ_STATUS    5'h0c
`define BPM_ADR_IRQ_MASK      5'h10
`define BPM_PMODE_LSB         0
`define BPM_IRQSEL_BIT        4
`define BPM_DETOFF_BIT        5
`define BPM_BIRQEN_BIT        5
`define BPM_GIRQEN_BIT        7
`define BPM_PONFLAG_BIT       4
`define BPM_BRFLAG_BIT        5
`define BPM_PMODE_TOTAL_DOWN  2'h3
`define BPM_REG_RESET         8'h00
`define BPM_IST_BROWNOUT      0
`define BPM_IST_POWERON       1
`endif

/* design/bpm_ctrl_if.sv */
// Control bits passed from the register file to the brownout decision logic.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface bpm_ctrl_if;
   logic [1:0] power_mode_select;
   logic       brownout_detect_off;
   logic       brownout_irq_select;
   logic       brownout_irq_enable;
   logic       global_irq_enable;
   logic       brownout_fuse_enable;
   logic       detectEnabled;
   logic       brownoutEvent;
   logic       brownoutCondition;
   modport regs (output power_mode_select, brownout_detect_off,
                 brownout_irq_select, brownout_irq_enable,
                 global_irq_enable, brownout_fuse_enable,
                 input detectEnabled, brownoutEvent, brownoutCondition);
   modport decide (input power_mode_select, brownout_detect_off,
                   brownout_irq_select, brownout_irq_enable,
                   global_irq_enable, brownout_fuse_enable,
                   output detectEnabled, brownoutEvent, brownoutCondition);
endinterface : bpm_ctrl_if

/* design/bpm_pkg.sv */
// Types shared by the supply monitor modules.
// Assumes bpm_cfg.svh is included by users of the constants.
package bpm_pkg;
   typedef enum logic [2:0] {
      ACT_IDLE      = 3'b001,
      ACT_RESET     = 3'b010,
      ACT_INTERRUPT = 3'b100
   } action_t;
endpackage : bpm_pkg

/* design/brownout_decide.sv */
// Decides detection enable and reset/interrupt routing of a brownout.
// Assumes the comparator level is already synchronised to clock.
`timescale 1ns/1ps
`include "bpm_cfg.svh"
module brownout_decide (
   input  wire logic   clock,
   input  wire logic   rst_n,
   input  wire logic   clockEnable,
   input  wire logic   comparatorLow,
   bpm_ctrl_if.decide  ctrl,
   output logic        cpuResetReq,
   output logic        brownoutIrq
);
   logic             lastCond;
   bpm_pkg::action_t action;

   // Fuse, mode field and off bit gate the whole detector
   assign ctrl.detectEnabled = ctrl.brownout_fuse_enable //RULE3
      && (ctrl.power_mode_select != `BPM_PMODE_TOTAL_DOWN) //RULE4
      && !ctrl.brownout_detect_off; //RULE5
   assign ctrl.brownoutCondition = ctrl.detectEnabled && comparatorLow; //RULE6
   assign ctrl.brownoutEvent = ctrl.brownoutCondition && !lastCond; //RULE7

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lastCond <= 1'b0;
      end else if (clockEnable) begin
         lastCond <= ctrl.brownoutCondition;
      end
   end

   always_comb begin
      if (!ctrl.brownout_irq_select) begin
         action = bpm_pkg::ACT_RESET; //RULE1
      end else if (ctrl.brownout_irq_enable && ctrl.global_irq_enable) begin
         action = bpm_pkg::ACT_INTERRUPT; //RULE2 RULE13
      end else begin
         action = bpm_pkg::ACT_IDLE; //RULE13
      end
   end

   // Registered so the reset line is glitch free toward the core
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cpuResetReq <= 1'b0;
         brownoutIrq <= 1'b0;
      end else if (clockEnable) begin
         case (action)
            bpm_pkg::ACT_RESET: begin
               cpuResetReq <= ctrl.brownoutCondition; //RULE15
               brownoutIrq <= 1'b0;
            end
            bpm_pkg::ACT_INTERRUPT: begin
               cpuResetReq <= 1'b0;
               brownoutIrq <= ctrl.brownoutCondition; //RULE14
            end
            default: begin
               cpuResetReq <= 1'b0;
               brownoutIrq <= 1'b0;
            end
         endcase
      end
   end
endmodule : brownout_decide

/* design/brownout_poweron_monitor.sv */
// Top of the supply monitor: Wishbone register file, flags and interrupt.
// Assumes analog detector levels arrive asynchronously and are synchronised.
`timescale 1ns/1ps
`include "bpm_cfg.svh"
module brownout_poweron_monitor (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        clockEnable,
   input  wire logic        comparatorLow,
   input  wire logic        powerOnDetect,
   input  wire logic        brownout_fuse_enable,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             cpuResetReq,
   output logic             brownoutIrq,
   output logic             irq
);
   logic [1:0] cmpSync;
   logic [1:0] porSync;
   logic [1:0] fuseSync;
   logic       porLast;
   logic [7:0] power_control_reg;
   logic [7:0] irq_enable_reg0;
   logic [7:0] reset_source_reg;
   logic [1:0] irqStatus;
   logic [1:0] irqMask;
   logic [31:0] next_dat;
   logic       access;
   logic       wrLane0;
   logic       porEvent;
   logic       brownFlagClear;
   logic       powerFlagClear;

   bpm_ctrl_if ctrl ();

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmpSync  <= 2'h0;
         porSync  <= 2'h0;
         fuseSync <= 2'h0;
      end else if (clockEnable) begin
         cmpSync  <= {cmpSync[0], comparatorLow};
         porSync  <= {porSync[0], powerOnDetect};
         fuseSync <= {fuseSync[0], brownout_fuse_enable};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         porLast <= 1'b0;
      end else if (clockEnable) begin
         porLast <= porSync[1];
      end
   end
   assign porEvent = porSync[1] && !porLast; //RULE11

   assign ctrl.power_mode_select   = power_control_reg[`BPM_PMODE_LSB +: 2];
   assign ctrl.brownout_detect_off = power_control_reg[`BPM_DETOFF_BIT];
   assign ctrl.brownout_irq_select = power_control_reg[`BPM_IRQSEL_BIT];
   assign ctrl.brownout_irq_enable = irq_enable_reg0[`BPM_BIRQEN_BIT];
   assign ctrl.global_irq_enable   = irq_enable_reg0[`BPM_GIRQEN_BIT];
   assign ctrl.brownout_fuse_enable = fuseSync[1];

   brownout_decide decide (
      .clock         (clock),
      .rst_n         (rst_n),
      .clockEnable   (clockEnable),
      .comparatorLow (cmpSync[1]),
      .ctrl          (ctrl),
      .cpuResetReq   (cpuResetReq),
      .brownoutIrq   (brownoutIrq)
   );

   // Single-cycle answer; ack drops the cycle after it was given
   assign access  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wrLane0 = access && wb_we_i && wb_sel_i[0];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else if (clockEnable) begin
         wb_ack_o <= access;
      end
   end

   function automatic logic hit(input logic [4:0] adr, input logic [4:0] off);
      hit = (adr[4:2] == off[4:2]);
   endfunction : hit

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         power_control_reg <= `BPM_REG_RESET; //RULE5
      end else if (clockEnable && wrLane0
                   && hit(wb_adr_i, 5'(`BPM_ADR_POWER_CONTROL))) begin
         power_control_reg <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable_reg0 <= `BPM_REG_RESET;
      end else if (clockEnable && wrLane0
                   && hit(wb_adr_i, 5'(`BPM_ADR_IRQ_ENABLE0))) begin
         irq_enable_reg0 <= wb_dat_i[7:0];
      end
   end

   // Flags clear only on a written zero; a new event wins over the clear
   assign brownFlagClear = wrLane0
                           && hit(wb_adr_i, 5'(`BPM_ADR_RESET_SOURCE))
                           && !wb_dat_i[`BPM_BRFLAG_BIT]; //RULE8
   assign powerFlagClear = wrLane0
                           && hit(wb_adr_i, 5'(`BPM_ADR_RESET_SOURCE))
                           && !wb_dat_i[`BPM_PONFLAG_BIT]; //RULE12

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_source_reg <= `BPM_REG_RESET;
      end else if (clockEnable) begin
         if (ctrl.brownoutEvent || (porEvent && fuseSync[1])) begin
            reset_source_reg[`BPM_BRFLAG_BIT] <= 1'b1; //RULE7 RULE10
         end else if (brownFlagClear) begin
            reset_source_reg[`BPM_BRFLAG_BIT] <= 1'b0; //RULE8
         end
         if (porEvent) begin
            reset_source_reg[`BPM_PONFLAG_BIT] <= 1'b1; //RULE11
         end else if (powerFlagClear) begin
            reset_source_reg[`BPM_PONFLAG_BIT] <= 1'b0; //RULE12
         end
      end
   end

   // Sticky interrupt status, write one to clear; set wins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irqStatus <= 2'h0;
      end else if (clockEnable) begin
         if (ctrl.brownoutEvent) begin
            irqStatus[`BPM_IST_BROWNOUT] <= 1'b1;
         end else if (wrLane0 && hit(wb_adr_i, 5'(`BPM_ADR_IRQ_STATUS))
                      && wb_dat_i[`BPM_IST_BROWNOUT]) begin
            irqStatus[`BPM_IST_BROWNOUT] <= 1'b0;
         end
         if (porEvent) begin
            irqStatus[`BPM_IST_POWERON] <= 1'b1;
         end else if (wrLane0 && hit(wb_adr_i, 5'(`BPM_ADR_IRQ_STATUS))
                      && wb_dat_i[`BPM_IST_POWERON]) begin
            irqStatus[`BPM_IST_POWERON] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irqMask <= 2'h0;
      end else if (clockEnable && wrLane0
                   && hit(wb_adr_i, 5'(`BPM_ADR_IRQ_MASK))) begin
         irqMask <= wb_dat_i[1:0];
      end
   end

   assign irq = |(irqStatus & irqMask);

   always_comb begin
      next_dat = 32'h0;
      case (wb_adr_i[4:2])
         3'h0: next_dat = {24'h0, power_control_reg};
         3'h1: next_dat = {24'h0, irq_enable_reg0};
         3'h2: next_dat = {24'h0, reset_source_reg};
         3'h3: next_dat = {30'h0, irqStatus};
         3'h4: next_dat = {30'h0, irqMask};
         default: next_dat = 32'h0;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= 32'h0;
      end else if (clockEnable && access) begin
         wb_dat_o <= next_dat;
      end
   end
endmodule : brownout_poweron_monitor

/* dv/brownout_poweron_monitor_chk.sv */
// Port-level assertions for the supply monitor top.
// Assumes one clock domain and the registered one-cycle ack.
`timescale 1ns/1ps
module brownout_poweron_monitor_chk (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        clockEnable,
   input wire logic        comparatorLow,
   input wire logic        brownout_fuse_enable,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [4:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        cpuResetReq,
   input wire logic        brownoutIrq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   ack_pulse_a: assert property (wb_ack_o && clockEnable |=> !wb_ack_o)
      else $error("ack held too long");
   ack_time_a: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o && clockEnable |=> wb_ack_o)
      else $error("ack late");
   ack_cause_a: assert property
      (!(wb_cyc_i && wb_stb_i) && clockEnable |=> !wb_ack_o)
      else $error("ack without request");
   upper_zero_a: assert property
      (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits set");
   unmapped_rd_a: assert property
      (wb_ack_o && !wb_we_i && wb_adr_i[4:2] > 3'h4 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   // Five cycles cover the two-flop sync and the output register
   fuse_off_a: assert property (
      !brownout_fuse_enable [*5] |-> !cpuResetReq && !brownoutIrq)
      else $error("action with fuse off");
   supply_ok_a: assert property (
      !comparatorLow [*5] |-> !cpuResetReq && !brownoutIrq)
      else $error("action without brownout");
   route_excl_a: assert property (!(cpuResetReq && brownoutIrq))
      else $error("reset and irq together");
   reset_hold_a: assert property (
      (cpuResetReq && comparatorLow && brownout_fuse_enable && !wb_cyc_i)
      [*5] |=> cpuResetReq)
      else $error("reset dropped early");
endmodule : brownout_poweron_monitor_chk
bind brownout_poweron_monitor brownout_poweron_monitor_chk chk (
   .clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
   .comparatorLow(comparatorLow),
   .brownout_fuse_enable(brownout_fuse_enable),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .cpuResetReq(cpuResetReq), .brownoutIrq(brownoutIrq));

/* dv/cpu_partner.sv */
// CPU-side model: counts reset entries and brownout interrupts taken.
// Assumes both requests are levels on the system clock.
`timescale 1ns/1ps
module cpu_partner (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic resetIn,
   input  wire logic irqIn,
   output int        resetCount,
   output int        irqCount
);
   logic lastReset;
   logic lastIrq;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lastReset <= 1'b0;
         lastIrq <= 1'b0;
         resetCount <= 0;
         irqCount <= 0;
      end else begin
         lastReset <= resetIn;
         lastIrq <= irqIn;
         if (resetIn && !lastReset) resetCount <= resetCount + 1;
         if (irqIn && !lastIrq) irqCount <= irqCount + 1;
      end
   end
endmodule : cpu_partner

/* dv/test_brownout_poweron_monitor.sv */
// Self-checking bench: Wishbone master, analog levels, CPU model.
// Assumes ack one cycle after the take and a two-flop input sync.
`timescale 1ns/1ps
module test_brownout_poweron_monitor;
   logic        clock = 0, rst_n = 0, clockEnable = 1, fuse = 1;
   logic        low = 0, pwrOn = 0, cyc = 0, stb = 0, we = 0;
   logic [4:0]  adr = 5'h00;
   logic [31:0] datW = 32'h0, datR, rd;
   logic        ack, rstReq, boIrq, irq;
   int          error_cnt = 0, compares = 0, cycles = 0, resets, irqs;
   always #2.5 clock = ~clock;
   brownout_poweron_monitor DUT (.clock(clock), .rst_n(rst_n),
      .clockEnable(clockEnable), .comparatorLow(low),
      .powerOnDetect(pwrOn), .brownout_fuse_enable(fuse),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
      .cpuResetReq(rstReq), .brownoutIrq(boIrq), .irq(irq));
   cpu_partner cpu (.clock(clock), .rst_n(rst_n), .resetIn(rstReq),
      .irqIn(boIrq), .resetCount(resets), .irqCount(irqs));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      datW <= d;
      do @(posedge clock); while (ack !== 1'b1);
      rd = datR;
      cyc <= 0;
      stb <= 0;
      we <= 0;
   endtask : bus
   task settle;
      repeat (6) @(posedge clock);
   endtask : settle
   task t_regs;
      bus(1, 5'h14, 32'hff);
      for (int i = 0; i < 6; i++) begin
         bus(0, 5'(i * 4), 32'h0);
         chk(rd, 32'h0);
      end
      $display("test regs done");
   endtask : t_regs
   task t_power_on;
      pwrOn <= 1;
      settle;
      bus(0, 5'h08, 32'h0);
      chk(rd, 32'h30);
      bus(1, 5'h08, 32'h20);
      bus(0, 5'h08, 32'h0);
      chk(rd, 32'h20);
      bus(1, 5'h08, 32'h0);
      bus(0, 5'h0c, 32'h0);
      chk(rd, 32'h02);
      chk(irq, 1'b0);
      bus(1, 5'h10, 32'h02);
      chk(irq, 1'b1);
      bus(1, 5'h0c, 32'h02);
      chk(irq, 1'b0);
      bus(1, 5'h10, 32'h0);
      pwrOn <= 0;
      $display("test power-on done");
   endtask : t_power_on
   task t_detect;
      logic [7:0] pc [5] = '{8'h00, 8'h02, 8'h03, 8'h20, 8'h00};
      logic       fu [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      logic       ex [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      for (int i = 0; i < 5; i++) begin
         fuse <= fu[i];
         bus(1, 5'h00, {24'h0, pc[i]});
         low <= 1;
         settle;
         chk(rstReq, ex[i]);
         chk(boIrq, 1'b0);
         low <= 0;
         settle;
         chk(rstReq, 1'b0);
         bus(0, 5'h08, 32'h0);
         // Flag has no meaning with the fuse off, so it is not judged
         if (fu[i]) chk(rd, ex[i] ? 32'h20 : 32'h0);
         bus(1, 5'h08, 32'h0);
         bus(1, 5'h0c, 32'h03);
      end
      chk(resets, 2);
      fuse <= 1;
      bus(1, 5'h00, 32'h0);
      $display("test detect done");
   endtask : t_detect
   task t_irq;
      logic [7:0] en [3] = '{8'ha0, 8'h20, 8'h80};
      logic       ex [3] = '{1'b1, 1'b0, 1'b0};
      bus(1, 5'h00, 32'h10);
      bus(1, 5'h10, 32'h01);
      for (int i = 0; i < 3; i++) begin
         bus(1, 5'h04, {24'h0, en[i]});
         low <= 1;
         settle;
         chk(boIrq, ex[i]);
         chk(rstReq, 1'b0);
         chk(irq, 1'b1);
         bus(1, 5'h0c, 32'h01);
         chk(irq, 1'b0);
         bus(0, 5'h08, 32'h0);
         chk(rd, 32'h20);
         low <= 0;
         settle;
         bus(1, 5'h08, 32'h0);
      end
      chk(irqs, 1);
      $display("test irq done");
   endtask : t_irq
   task conclude;
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         conclude;
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1;
      t_regs;
      t_power_on;
      t_detect;
      t_irq;
      conclude;
   end
endmodule : test_brownout_poweron_monitor
